// File: core/cwp_config_protect.sv
// Configuration word decode, protection, ID words and start-up timing
//
// Overview of operation
// RQ1: Configuration word sits at location 2007h
// RQ2: Bit 13 low enables in-circuit debug
// RQ3: Unimplemented config bits always read one
// RQ4: Two-bit field sets self-write protected range
// RQ5: Self-writes only via control register, unprotected
// RQ6: Code protect blocks external writes, reads zero
// RQ7: Internal program reads never gated by protection
// RQ8: Bit 5 selects reset pin and pull-up
// RQ9: Bit 4 low enables power-up timer
// RQ10: Bit 3 high enables watchdog
// RQ11: ID words 2000h-2003h only in program mode
// RQ12: Tools keep debug bit one normally
// RQ13: Power-up timer holds reset after power-on
// RQ14: Watchdog resets unless cleared in time
// RQ15: Word latched at reset, held constant after
`timescale 1ns/1ps
`default_nettype none

module cwp_config_protect #(
  parameter int unsigned POWERUP_TIMER_CYCLES = cwp_pkg::POWERUP_TIMER_CYCLES,  // Power-up hold
  parameter int unsigned WDT_CYCLES  = cwp_pkg::WDT_CYCLES    // Watchdog period
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  // Non-volatile word and chip pins
  input  wire logic [13:0] cfgNvWord,
  input  wire logic        master_clear_pin,
  input  wire logic        watchdog_clear_instr,
  // Programmer port
  input  wire logic        progMode,
  input  wire logic        extReq,
  input  wire logic        extWrite,
  input  wire logic [13:0] extAddr,
  input  wire logic [13:0] extWdata,
  output var  logic        extAck,
  output var  logic [13:0] extRdata,
  // Program memory array
  input  wire logic [13:0] pmRdata,
  output var  logic        pmRdEn,
  output var  logic        pmWrEn,
  output var  logic [11:0] pmAddr,
  output var  logic [13:0] pmWdata,
  // Decoded options
  output var  logic        debugModeEn,
  output var  logic        resetPinFuncEn,
  output var  logic        resetPinPullupEn,
  output var  logic        wdtEnabled,
  output var  logic        chipResetHold,
  output var  logic        wdtResetPulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cwp_pkg::cwp_ext_state_e extState, next_extState;  // Programmer sequencer

  logic [13:0] cfgWord,     next_cfgWord;      // Latched configuration word
  logic        cfgLoaded,   next_cfgLoaded;    // Word latched since reset
  logic        pwrtRun,     next_pwrtRun;      // Power-up timer active
  logic        dpWrite,     next_dpWrite;      // Bus write data phase pending
  logic [15:0] dpAddr,      next_dpAddr;       // Bus data phase address
  logic [11:0] selfAdr,     next_selfAdr;      // Self-write address
  logic [13:0] selfDat,     next_selfDat;      // Self-write data
  logic        selfPend,    next_selfPend;     // Self-write waiting for the port
  logic        selfErr,     next_selfErr;      // Sticky refusal flag
  logic [13:0] idWord [4];                     // ID words, not reset
  logic [13:0] next_idWord [4];
  logic [31:0] next_hrdata;
  logic        next_extAck, next_pmRdEn, next_pmWrEn;
  logic [13:0] next_extRdata, next_pmWdata;
  logic [11:0] next_pmAddr;
  logic        next_debugModeEn, next_resetPinFuncEn, next_wdtEnabled;
  logic        next_chipResetHold;
  logic        pwrtDone;                       // Power-up timer expiry
  logic        wdtClr;                         // Any watchdog clear
  logic        wdClrSw;                        // Watchdog clear from the bus
  logic        addrPhase;                      // Bus transfer taken this cycle
  logic        busHit;                         // Upper address bits are zero

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Lowest address that a self-write may touch
  function automatic logic [12:0] protLimit(input logic [1:0] sel);
    logic [12:0] lim;
    case (sel)
      2'b11:   lim = cwp_pkg::PROT_LIM_11;
      2'b10:   lim = cwp_pkg::PROT_LIM_10;
      2'b01:   lim = cwp_pkg::PROT_LIM_01;
      default: lim = cwp_pkg::PM_TOP;  // Whole array protected
    endcase
    return lim;
  endfunction : protLimit

  // Readback view of the word
  function automatic logic [13:0] cfgView(input logic [13:0] w);
    return w | cwp_pkg::UNIMPL_MASK;  // RQ3
  endfunction : cfgView

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  // Runs from release of reset; expiry frees the chip
  cwp_timeout #(
    .LIMIT   (POWERUP_TIMER_CYCLES)
  ) u_powerup_timer (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .countEn (pwrtRun),                  // RQ13
    .restart (1'b0),
    .expired (pwrtDone)
  );

  // Counts only while the chip runs, so a held reset never trips it
  cwp_timeout #(
    .LIMIT   (WDT_CYCLES)
  ) u_wdt (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .countEn (wdtEnabled & ~chipResetHold),  // RQ14
    .restart (wdtClr),
    .expired (wdtResetPulse)                 // RQ14
  );

  assign addrPhase = hsel & htrans[1] & hready;
  assign busHit    = (haddr[31:16] == 16'h0000);
  assign wdClrSw   = dpWrite & (dpAddr == cwp_pkg::A_CTRL) & hwdata[cwp_pkg::C_WDCLR];
  assign wdtClr    = watchdog_clear_instr | wdClrSw;  // RQ14

  // ----------------------------------------------------------------
  // Next-state logic for everything
  // ----------------------------------------------------------------
  always_comb begin
    logic        isPm;       // Programmer address in program memory
    logic        isId;       // Programmer address in ID words
    logic        cpOn;       // Code protection active
    logic        errSet;     // Self-write refused this cycle
    logic        errClr;     // Software clears the refusal flag
    isPm   = (extAddr[13:12] == 2'b00);
    isId   = (extAddr[13:2] == cwp_pkg::ID_BASE[13:2]);
    cpOn   = ~cfgWord[cwp_pkg::B_CP_N];
    errSet = 1'b0;
    errClr = 1'b0;
    next_extState  = extState;
    next_cfgWord   = cfgWord;
    next_cfgLoaded = cfgLoaded;
    next_pwrtRun   = pwrtRun;
    next_selfAdr   = selfAdr;
    next_selfDat   = selfDat;
    next_selfPend  = selfPend;
    next_idWord    = idWord;
    next_extRdata  = extRdata;
    next_pmAddr    = pmAddr;
    next_pmWdata   = pmWdata;
    next_hrdata    = hrdata;
    next_extAck    = 1'b0;
    next_pmRdEn    = 1'b0;
    next_pmWrEn    = 1'b0;

    // Latch once after reset, never reloaded
    if (!cfgLoaded) begin
      next_cfgWord   = cfgNvWord;                     // RQ15
      next_cfgLoaded = 1'b1;                          // RQ15
      next_pwrtRun   = ~cfgNvWord[cwp_pkg::B_POWERUP_TIMER_N]; // RQ9
    end else if (pwrtDone) begin
      next_pwrtRun = 1'b0;                            // RQ13
    end

    // Decoded options follow the held word
    next_debugModeEn    = ~next_cfgWord[cwp_pkg::B_DEBUG_N];  // RQ2
    next_resetPinFuncEn = next_cfgWord[cwp_pkg::B_RPIN];      // RQ8
    next_wdtEnabled     = next_cfgWord[cwp_pkg::B_WDT];       // RQ10
    // Hold until latched, timed out and the pin released
    next_chipResetHold  = ~cfgLoaded | next_pwrtRun
                        | (next_resetPinFuncEn & ~master_clear_pin);  // RQ8

    // Bus data phase of a write
    next_dpWrite = addrPhase & hwrite & busHit;
    next_dpAddr  = addrPhase ? haddr[15:0] : dpAddr;
    if (dpWrite) begin
      case (dpAddr)
        cwp_pkg::A_CTRL: begin
          // Self-write goes only through this strobe
          if (hwdata[cwp_pkg::C_SWSTART]) begin
            next_selfPend = 1'b1;  // RQ5
          end
        end
        cwp_pkg::A_STATUS: begin
          errClr = hwdata[cwp_pkg::S_WR_ERR];
        end
        cwp_pkg::A_PMADR: begin
          next_selfAdr = hwdata[11:0];
        end
        cwp_pkg::A_PMDAT: begin
          next_selfDat = hwdata[13:0];
        end
        default: begin
          // Read-only or unmapped, write dropped
        end
      endcase
    end

    // Bus read data, registered so the slave answers with no wait
    if (addrPhase && !hwrite) begin
      next_hrdata = 32'h0000_0000;
      if (busHit) begin
        case (haddr[15:0])
          cwp_pkg::A_STATUS: begin
            next_hrdata[0] = debugModeEn;
            next_hrdata[1] = ~cfgWord[cwp_pkg::B_CP_N];
            next_hrdata[2] = resetPinFuncEn;
            next_hrdata[3] = ~cfgWord[cwp_pkg::B_POWERUP_TIMER_N];
            next_hrdata[4] = wdtEnabled;
            next_hrdata[6:5] = cfgWord[cwp_pkg::B_WRT_HI:cwp_pkg::B_WRT_LO];
            next_hrdata[cwp_pkg::S_POWERUP_TIMER_BUSY] = pwrtRun;
            next_hrdata[cwp_pkg::S_WR_ERR]    = selfErr;
            next_hrdata[cwp_pkg::S_LOADED]    = cfgLoaded;
          end
          cwp_pkg::A_PMADR:  next_hrdata[11:0] = selfAdr;
          cwp_pkg::A_PMDAT:  next_hrdata[13:0] = selfDat;
          cwp_pkg::A_CONFIG: next_hrdata[13:0] = cfgView(cfgWord);  // RQ1
          default:           next_hrdata = 32'h0000_0000;  // Control and unmapped
        endcase
      end
    end

    // Memory port and programmer sequencer
    case (extState)
      cwp_pkg::EXT_IDLE: begin
        if (selfPend) begin
          // Self-write owns the port this cycle; programmer waits
          next_selfPend = 1'b0;
          if ({1'b0, selfAdr} < protLimit(cfgWord[cwp_pkg::B_WRT_HI:cwp_pkg::B_WRT_LO])) begin
            errSet = 1'b1;  // RQ4
          end else begin
            next_pmWrEn  = 1'b1;  // RQ5
            next_pmAddr  = selfAdr;
            next_pmWdata = selfDat;
          end
        end else if (extReq) begin
          next_extAck   = 1'b1;
          next_extRdata = 14'h0000;
          if (isPm) begin
            if (extWrite) begin
              // Writes dropped under protection
              next_pmWrEn  = ~cpOn;  // RQ6
              next_pmAddr  = extAddr[11:0];
              next_pmWdata = extWdata;
            end else if (!cpOn) begin
              next_extAck   = 1'b0;
              next_pmRdEn   = 1'b1;
              next_pmAddr   = extAddr[11:0];
              next_extState = cwp_pkg::EXT_PMRD;
            end
          end else if (isId && progMode) begin
            if (extWrite) begin
              next_idWord[extAddr[1:0]] = extWdata;  // RQ11
            end else begin
              next_extRdata = idWord[extAddr[1:0]];  // RQ11
            end
          end else if (extAddr == cwp_pkg::CFG_INDEX && !extWrite) begin
            next_extRdata = cfgView(cfgWord);  // RQ3
          end
        end
      end
      cwp_pkg::EXT_PMRD: begin
        next_extState = cwp_pkg::EXT_PMWT;
      end
      cwp_pkg::EXT_PMWT: begin
        // Only the programmer path is gated; core fetches bypass this block
        next_extRdata = cpOn ? 14'h0000 : pmRdata;  // RQ7
        next_extAck   = 1'b1;
        next_extState = cwp_pkg::EXT_IDLE;
      end
      default: begin
        next_extState = cwp_pkg::EXT_IDLE;
      end
    endcase

    // Sticky refusal flag; a new refusal wins
    next_selfErr = (selfErr & ~errClr) | errSet;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // ID words survive reset, like the array
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      idWord[i] <= next_idWord[i];
    end
  end

  // Control state and outputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      extState         <= cwp_pkg::EXT_IDLE;
      cfgWord          <= 14'h3FFF;  // Erased word until latched
      cfgLoaded        <= 1'b0;
      pwrtRun          <= 1'b0;
      dpWrite          <= 1'b0;
      dpAddr           <= 16'h0000;
      selfAdr          <= 12'h000;
      selfDat          <= 14'h0000;
      selfPend         <= 1'b0;
      selfErr          <= 1'b0;
      hreadyout        <= 1'b1;
      hrdata           <= 32'h0000_0000;
      hresp            <= 1'b0;
      extAck           <= 1'b0;
      extRdata         <= 14'h0000;
      pmRdEn           <= 1'b0;
      pmWrEn           <= 1'b0;
      pmAddr           <= 12'h000;
      pmWdata          <= 14'h0000;
      debugModeEn      <= 1'b0;
      resetPinFuncEn   <= 1'b0;
      resetPinPullupEn <= 1'b0;
      wdtEnabled       <= 1'b0;
      chipResetHold    <= 1'b1;
    end else begin
      extState         <= next_extState;
      cfgWord          <= next_cfgWord;
      cfgLoaded        <= next_cfgLoaded;
      pwrtRun          <= next_pwrtRun;
      dpWrite          <= next_dpWrite;
      dpAddr           <= next_dpAddr;
      selfAdr          <= next_selfAdr;
      selfDat          <= next_selfDat;
      selfPend         <= next_selfPend;
      selfErr          <= next_selfErr;
      hreadyout        <= 1'b1;  // Never stretches a transfer
      hrdata           <= next_hrdata;
      hresp            <= 1'b0;  // Always OKAY
      extAck           <= next_extAck;
      extRdata         <= next_extRdata;
      pmRdEn           <= next_pmRdEn;
      pmWrEn           <= next_pmWrEn;
      pmAddr           <= next_pmAddr;
      pmWdata          <= next_pmWdata;
      debugModeEn      <= next_debugModeEn;
      resetPinFuncEn   <= next_resetPinFuncEn;
      resetPinPullupEn <= next_resetPinFuncEn;  // RQ8
      wdtEnabled       <= next_wdtEnabled;
      chipResetHold    <= next_chipResetHold;
    end
  end

endmodule : cwp_config_protect

`default_nettype wire

// File: core/cwp_pkg.sv
// Constants, register map and state types for the protection block
package cwp_pkg;

  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  localparam logic [13:0] CFG_INDEX    = 14'h2007;  // Printed location of the word
  localparam int          B_DEBUG_N    = 13;        // Debug enable, active low
  localparam int          B_WRT_HI     = 11;        // Self-write protect select, high
  localparam int          B_WRT_LO     = 10;        // Self-write protect select, low
  localparam int          B_CP_N       = 6;         // Code protect, active low
  localparam int          B_RPIN       = 5;         // Reset pin function select
  localparam int          B_POWERUP_TIMER_N     = 4;         // Power-up timer enable, active low
  localparam int          B_WDT        = 3;         // Watchdog enable
  localparam logic [13:0] UNIMPL_MASK  = 14'h1387;  // Bits 12, 9-7, 2-0 read as one

  // ----------------------------------------------------------------
  // Programmer address space
  // ----------------------------------------------------------------
  localparam logic [12:0] PM_TOP       = 13'h1000;  // End of program memory
  localparam logic [12:0] PROT_LIM_10  = 13'h0400;  // Protect 000h-3FFh
  localparam logic [12:0] PROT_LIM_01  = 13'h0800;  // Protect 000h-7FFh
  localparam logic [12:0] PROT_LIM_11  = 13'h0000;  // Nothing protected
  localparam logic [13:0] ID_BASE      = 14'h2000;  // First of four ID words

  // ----------------------------------------------------------------
  // Bus register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] A_CTRL       = 16'h0000;  // Control strobes
  localparam logic [15:0] A_STATUS     = 16'h0004;  // Decoded options and flags
  localparam logic [15:0] A_PMADR      = 16'h0008;  // Self-write address
  localparam logic [15:0] A_PMDAT      = 16'h000C;  // Self-write data
  localparam logic [15:0] A_CONFIG     = {CFG_INDEX, 2'b00};  // Index times four
  localparam int          C_WDCLR      = 0;         // Control: clear watchdog
  localparam int          C_SWSTART    = 1;         // Control: start self-write
  localparam int          S_POWERUP_TIMER_BUSY  = 7;         // Status: power-up timer running
  localparam int          S_WR_ERR     = 8;         // Status: self-write refused, W1C
  localparam int          S_LOADED     = 9;         // Status: word latched

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned POWERUP_TIMER_MS      = 64;        // Nominal power-up hold
  localparam int unsigned WDT_MS       = 16;        // Plain default watchdog period
  localparam int unsigned POWERUP_TIMER_CYCLES  = POWERUP_TIMER_MS * (CLK_HZ / 1000);
  localparam int unsigned WDT_CYCLES   = WDT_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Programmer access sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EXT_IDLE = 2'b00,  // Waiting for a request
    EXT_PMRD = 2'b01,  // Read strobe at memory
    EXT_PMWT = 2'b10   // Memory data valid
  } cwp_ext_state_e;

endpackage : cwp_pkg

// File: core/cwp_timeout.sv
// Timeout counter with restart, for power-up and watchdog timing
`timescale 1ns/1ps
`default_nettype none

module cwp_timeout #(
  parameter int unsigned LIMIT = 4096  // Cycles to expiry
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic countEn,  // Count while high
  input  wire logic restart,  // Back to zero
  output var  logic expired   // One-cycle pulse at expiry
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  localparam logic [22:0] LAST = 23'(LIMIT - 1);  // Final count

  logic [22:0] count;       // Elapsed cycles
  logic [22:0] next_count;
  logic        next_expired;

  // Wraps at expiry so stuck firmware keeps getting resets
  always_comb begin
    next_count   = count;
    next_expired = 1'b0;
    if (restart) begin
      next_count = '0;
    end else if (countEn) begin
      if (count == LAST) begin
        next_count   = '0;
        next_expired = 1'b1;
      end else begin
        next_count = count + 23'd1;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count   <= '0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= next_expired;
    end
  end

endmodule : cwp_timeout

`default_nettype wire

// File: tb/cwp_checker.sv
// Port-level assertions for the protection block
`timescale 1ns/1ps
`default_nettype none

module cwp_checker (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [13:0] cfgNvWord,
  input wire logic        master_clear_pin,
  input wire logic        watchdog_clear_instr,
  input wire logic        extAck,
  input wire logic        pmRdEn,
  input wire logic        debugModeEn,
  input wire logic        resetPinFuncEn,
  input wire logic        resetPinPullupEn,
  input wire logic        wdtEnabled,
  input wire logic        chipResetHold,
  input wire logic        wdtResetPulse
);
  // ------------------------------------------------------------
  // Cycles since reset release, saturating at three
  // ------------------------------------------------------------
  logic [1:0] rstAge;  // Options valid from one
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rstAge <= 2'h0;
    end else if (rstAge != 2'h3) begin
      rstAge <= rstAge + 2'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Options due; word latched two edges earlier
  sequence optsDue;
    rstAge == 2'h2;
  endsequence
  // Programmer read acked two cycles after the strobe
  sequence pmReadDone;
    ##2 extAck;
  endsequence

  AST_DEBUG: assert property (optsDue |-> debugModeEn == !$past(cfgNvWord[13], 2))
    else $error("debug mode wrong");
  AST_PIN_SEL: assert property (optsDue |-> resetPinFuncEn == $past(cfgNvWord[5], 2))
    else $error("reset pin select wrong");
  AST_WDT_SEL: assert property (optsDue |-> wdtEnabled == $past(cfgNvWord[3], 2))
    else $error("watchdog enable wrong");
  AST_PULLUP: assert property (resetPinPullupEn == resetPinFuncEn)
    else $error("pull-up mismatch");
  AST_HELD: assert property (rstAge == 2'h3 |-> $stable({debugModeEn, resetPinFuncEn, wdtEnabled}))
    else $error("options changed");
  AST_START_HOLD: assert property (rstAge < 2'h2 |-> chipResetHold)
    else $error("core released early");
  AST_PIN_RESET: assert property (rstAge == 2'h3 && resetPinFuncEn && !master_clear_pin
      |-> ##[1:2] chipResetHold)
    else $error("pin did not hold core");
  AST_WDT_OFF: assert property (rstAge == 2'h3 && !wdtEnabled |-> !wdtResetPulse)
    else $error("watchdog fired while disabled");
  AST_WDT_CLEAR: assert property (watchdog_clear_instr |-> ##2 !wdtResetPulse [*8])
    else $error("watchdog fired after clear");
  AST_PM_READ: assert property (pmRdEn |-> pmReadDone)
    else $error("programmer read not answered");
endmodule : cwp_checker

bind cwp_config_protect cwp_checker u_chk (.clk_sys, .sys_rst, .cfgNvWord, .master_clear_pin,
  .watchdog_clear_instr, .extAck, .pmRdEn, .debugModeEn, .resetPinFuncEn,
  .resetPinPullupEn, .wdtEnabled, .chipResetHold, .wdtResetPulse);
`default_nettype wire

// File: tb/cwp_pm_model.sv
// Synchronous program memory array facing the block
`timescale 1ns/1ps
`default_nettype none

module cwp_pm_model (
  input  wire logic        clk_sys,
  input  wire logic        pmRdEn,
  input  wire logic        pmWrEn,
  input  wire logic [11:0] pmAddr,
  input  wire logic [13:0] pmWdata,
  output var  logic [13:0] pmRdata
);
  logic [13:0] mem [0:4095];  // Preset to a known pattern per address
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = {2'b10, 12'(i)};
    pmRdata = 14'h0000;
  end
  // Data valid one cycle, then inverted so stale reads show
  always @(posedge clk_sys) begin
    if (pmWrEn === 1'b1) mem[pmAddr] <= pmWdata;
    if (pmRdEn === 1'b1) pmRdata <= mem[pmAddr];
    else pmRdata <= ~pmRdata;
  end
endmodule : cwp_pm_model
`default_nettype wire

// File: tb/tb_config_word_and_code_protect.sv
// Self-checking bench for the protection block
`timescale 1ns/1ps
`default_nettype none

module tb_config_word_and_code_protect;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int PT = 20;  // Short power-up hold
  localparam int WD = 50;  // Short watchdog period
  logic        clk_sys = 0, sys_rst = 1, hsel = 0, hwrite = 0;
  logic        hreadyout, hresp, extAck, pmRdEn, pmWrEn;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, lastWa;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic [13:0] cfgNvWord = 14'h3FFF, extAddr = '0, extWdata = '0;
  logic [13:0] extRdata, pmRdata, pmWdata, r14;
  logic        master_clear_pin = 1, watchdog_clear_instr = 0;
  logic        progMode = 0, extReq = 0, extWrite = 0;
  logic [11:0] pmAddr;
  logic        debugModeEn, resetPinFuncEn, resetPinPullupEn;
  logic        wdtEnabled, chipResetHold, wdtResetPulse;
  wire         hready = hreadyout;  // Single slave drives the bus ready
  int          errors = 0, cmp_count = 0, wrCnt = 0, wdtCnt = 0;

  cwp_config_protect #(.POWERUP_TIMER_CYCLES(PT), .WDT_CYCLES(WD)) DUT (
    .clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .cfgNvWord, .master_clear_pin, .watchdog_clear_instr,
    .progMode, .extReq, .extWrite, .extAddr, .extWdata, .extAck, .extRdata, .pmRdata,
    .pmRdEn, .pmWrEn, .pmAddr, .pmWdata, .debugModeEn, .resetPinFuncEn,
    .resetPinPullupEn, .wdtEnabled, .chipResetHold, .wdtResetPulse);
  cwp_pm_model u_pm (.clk_sys, .pmRdEn, .pmWrEn, .pmAddr, .pmWdata, .pmRdata);

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Count memory writes and watchdog pulses
  always @(posedge clk_sys) begin
    if (pmWrEn === 1'b1) begin
      wrCnt++;
      lastWa = {pmWdata, pmAddr};
    end
    if (wdtResetPulse === 1'b1) wdtCnt++;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {16'h0000, a};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rdv = hrdata;
    check(hresp, 1'b0);
  endtask : ahb

  task automatic ext(input logic wr, input logic [13:0] a, input logic [13:0] wd,
                     output logic [13:0] rdv);
    extReq   <= 1'b1;
    extWrite <= wr;
    extAddr  <= a;
    extWdata <= wd;
    @(posedge clk_sys);
    extReq <= 1'b0;
    do @(posedge clk_sys); while (extAck !== 1'b1);
    rdv = extRdata;
  endtask : ext

  task automatic sw(input logic [11:0] a, input logic ok);
    int c;
    c = wrCnt;
    ahb(1'b1, cwp_pkg::A_PMADR, {20'h0_0000, a}, rd);
    ahb(1'b1, cwp_pkg::A_PMDAT, 32'h0000_0155, rd);
    ahb(1'b1, cwp_pkg::A_CTRL, 32'h0000_0002, rd);
    repeat (3) @(posedge clk_sys);
    check(wrCnt - c, ok);
    if (ok) check(lastWa, {14'h0155, a});
    ahb(1'b0, cwp_pkg::A_STATUS, '0, rd);
    check(rd[cwp_pkg::S_WR_ERR], !ok);
    ahb(1'b1, cwp_pkg::A_STATUS, 32'h0000_0100, rd);
  endtask : sw

  // One reset with word w; lim is the first writable address
  task automatic run_cfg(input logic [13:0] w, input logic [12:0] lim);
    int n, c;
    cfgNvWord <= w;
    sys_rst   <= 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (chipResetHold !== 1'b0);
    check(n > PT, !w[4]);
    check(debugModeEn, !w[13]);
    check({resetPinFuncEn, resetPinPullupEn}, {2{w[5]}});
    check(wdtEnabled, w[3]);
    ahb(1'b0, cwp_pkg::A_CONFIG, '0, rd);
    check(rd, {18'h0_0000, w | cwp_pkg::UNIMPL_MASK});
    ahb(1'b0, cwp_pkg::A_CONFIG + 16'h0004, '0, rd);
    check(rd, '0);
    ext(1'b0, 14'h0005, 14'h0000, r14);
    check(r14, w[6] ? 14'h2005 : 14'h0000);
    c = wrCnt;
    ext(1'b1, 14'h0006, 14'h1234, r14);
    ext(1'b0, 14'h0006, 14'h0000, r14);
    check(wrCnt - c, w[6]);
    check(r14, w[6] ? 14'h1234 : 14'h0000);
    ext(1'b0, 14'h2007, 14'h0000, r14);
    check(r14, w | cwp_pkg::UNIMPL_MASK);
    progMode <= 1'b1;
    ext(1'b1, 14'h2003, w, r14);
    ext(1'b0, 14'h2003, 14'h0000, r14);
    check(r14, w);
    progMode <= 1'b0;
    ext(1'b0, 14'h2003, 14'h0000, r14);
    check(r14, 14'h0000);
    if (lim != 13'h0000) sw(lim[11:0] - 12'h001, 1'b0);
    if (lim != 13'h1000) sw(lim[11:0], 1'b1);
    for (int i = 0; i < 8; i++) begin
      watchdog_clear_instr <= 1'b1;
      @(posedge clk_sys);
      watchdog_clear_instr <= 1'b0;
      repeat (9) @(posedge clk_sys);
      if (i == 0) c = wdtCnt;
    end
    check(wdtCnt - c, 0);
    repeat (WD + 10) @(posedge clk_sys);
    check(wdtCnt - c, w[3]);
    cfgNvWord        <= ~w;
    master_clear_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(debugModeEn, !w[13]);
    check(chipResetHold, w[5]);
    master_clear_pin <= 1'b1;
  endtask : run_cfg

  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------
  // Sequence: one pass per protect select code
  // ------------------------------------------------------------
  initial begin
    run_cfg(14'h3FFF, 13'h0000);
    run_cfg(14'h0800, 13'h0400);
    run_cfg(14'h2450, 13'h0800);
    run_cfg(14'h0068, 13'h1000);
    end_of_test();
  end
  // Hang guard, far beyond the run's length
  initial begin
    #100us;
    errors++;
    end_of_test();
  end
endmodule : tb_config_word_and_code_protect
`default_nettype wire
